// >>> vdls_pkg.sv
// Package of constants and types for the vertical driver level select block.
package vdls_pkg;

	// Two-bit level codes handed to the analog driver stage.
	typedef enum logic [1:0] {
		LVL_LOW_CODE = 2'h0,
		LVL_MID_CODE = 2'h1,
		LVL_HIGH_CODE = 2'h2
	} vdls_level_type;

	// Substrate clock level codes.
	localparam logic [1:0] SUB_HIGH = 2'h2;
	localparam logic [1:0] SUB_MID = 2'h1;
	localparam logic [1:0] SUB_LOW = 2'h0;

	// Register widths and reset values.
	localparam int SEL_W = 5;
	localparam logic [4:0] SEL_RESET = 5'h1F;
	localparam int NUM_PHASE = 13;
	localparam int NUM_GATE = 8;
	localparam int NUM_SHUT_SRC = 10;
	localparam int SHUT_SEL_W = 4;
	localparam logic [3:0] SHUT_SEL_RESET = 4'hF;

	// Shutter source select codes for the three shutter output pins.
	localparam logic [3:0] SRC_EXP0 = 4'h0;
	localparam logic [3:0] SRC_EXP1 = 4'h1;
	localparam logic [3:0] SRC_EXP2 = 4'h2;
	localparam logic [3:0] SRC_EXP3 = 4'h3;
	localparam logic [3:0] SRC_BIAS0 = 4'h4;
	localparam logic [3:0] SRC_BIAS1 = 4'h5;
	localparam logic [3:0] SRC_X_BIAS0 = 4'h6;
	localparam logic [3:0] SRC_X_BIAS1 = 4'h7;
	localparam logic [3:0] SRC_X_EXP1 = 4'h8;
	localparam logic [3:0] SRC_X_EXP2 = 4'h9;

	// Level-control source select codes.
	localparam logic [4:0] LC_INVALID = 5'h1D;
	localparam logic [4:0] LC_HIGH = 5'h1E;
	localparam logic [4:0] LC_LOW = 5'h1F;

endpackage : vdls_pkg

// >>> vdls_three_level.sv
// Three-level channel decoder for one vertical output.
`timescale 1ns/1ps
`default_nettype none
module vdls_three_level (
	input wire logic i_phase,
	input wire logic i_gate,
	output logic [1:0] o_level
);
	// Phase high forces low; otherwise the gate chooses mid over high.
	always_comb begin
		if (i_phase) begin
			o_level = vdls_pkg::LVL_LOW_CODE;
		end else if (i_gate) begin
			o_level = vdls_pkg::LVL_MID_CODE;
		end else begin
			o_level = vdls_pkg::LVL_HIGH_CODE;
		end
	end
endmodule : vdls_three_level
`default_nettype wire

// >>> vdls_top.sv
// Vertical driver level select: mixes phase and gate pulses into level codes.
// Function
// - Three-level output: phase high gives low, else gate high mid, else high.
// - Outputs 1, 3, 5A pair phases 1, 3, 5 with gates 1, 3, 5.
// - Output 5B pairs phase 5 with gate 6.
// - Outputs 7A and 7B pair phase 7 with gates 7 and 8.
// - Output 11 pairs phase 11 with gate 2; output 12 phase 12 with gate 4.
// - Two-level outputs 2,4,6,8,9,10,13: phase low gives mid, high gives low.
// - Substrate: pulse low gives high; else control low sub-mid, high sub-low.
// - Enable low forces vertical outputs to mid and substrate to sub-low.
// - Enable overrides phase and gate inputs at vertical and substrate outputs; level-control select still follows them when disabled.
// - Select codes 0-11 pick phases 6,8,9,10, gates 5-8, 2-4, 1.
// - Codes 12-28 pick further sources; 29 invalid, 30 high, 31 low.
// - Any exposure or bias pulse can drive any shutter output pin.
// - Shutter pins may output exposure 0 XORed with one of four pulses.
`timescale 1ns/1ps
`default_nettype none
module vdls_top (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [12:0] i_vertical_phase_inputs,
	input wire logic [7:0] i_sensor_gate_pulses,
	input wire logic i_substrate_pulse_in,
	input wire logic i_driver_enable_pin,
	input wire logic [3:0] i_exposure_pulses,
	input wire logic i_bias_pulse_0,
	input wire logic i_bias_pulse_1,
	input wire logic i_frame_trigger,
	input wire logic [4:0] i_substrate_level_source_sel,
	input wire logic [3:0] i_mech_shutter_sel,
	input wire logic [3:0] i_strobe_sel,
	input wire logic [3:0] i_bias_select_sel,
	output logic [1:0] o_v1,
	output logic [1:0] o_v2,
	output logic [1:0] o_v3,
	output logic [1:0] o_v4,
	output logic [1:0] o_phase5_out_a,
	output logic [1:0] o_phase5_out_b,
	output logic [1:0] o_v6,
	output logic [1:0] o_phase7_out_a,
	output logic [1:0] o_phase7_out_b,
	output logic [1:0] o_v8,
	output logic [1:0] o_v9,
	output logic [1:0] o_v10,
	output logic [1:0] o_v11,
	output logic [1:0] o_v12,
	output logic [1:0] o_v13,
	output logic [1:0] o_substrate_clock_out,
	output logic o_substrate_level_ctl,
	output logic o_mech_shutter_out,
	output logic o_strobe_out,
	output logic o_bias_select_out
);
	// All registered state of the block.
	typedef struct packed {
		logic [1:0] v1, v2, v3, v4, v5a, v5b, v6, v7a, v7b, v8, v9, v10, v11, v12, v13;
		logic [1:0] sub;
		logic lvl_ctl;
		logic mech_shutter_out, strobe, bsel;
		logic [12:0] ph_s1, ph_s2;
		logic [7:0] sg_s1, sg_s2;
		logic [7:0] misc_s1, misc_s2;
		logic en_s1, en_s2;
	} vdls_state_type;

	vdls_state_type st;
	vdls_state_type next_st;

	// Synchronised copies of the pin inputs.
	logic [12:0] ph;
	logic [7:0] sg;
	logic [3:0] ex;
	logic b0, b1, ftrig, sub_pulse, enable;
	assign ph = st.ph_s2;
	assign sg = st.sg_s2;
	assign ex = st.misc_s2[3:0];
	assign b0 = st.misc_s2[4];
	assign b1 = st.misc_s2[5];
	assign ftrig = st.misc_s2[6];
	assign sub_pulse = st.misc_s2[7];
	assign enable = st.en_s2;

	// Three-level channels: 1, 3, 5A, 5B, 7A, 7B, 11, 12.
	logic [7:0] tl_phase;
	logic [7:0] tl_gate;
	logic [1:0] tl_level [8];
	assign tl_phase = {ph[11], ph[10], ph[6], ph[6], ph[4], ph[4], ph[2], ph[0]};
	assign tl_gate = {sg[3], sg[1], sg[7], sg[6], sg[5], sg[4], sg[2], sg[0]};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_three
			vdls_three_level u_three (
				.i_phase(tl_phase[gi]),
				.i_gate(tl_gate[gi]),
				.o_level(tl_level[gi])
			);
		end
	endgenerate

	// Shutter source choice, plain or XOR with exposure pulse 0.
	function automatic logic shut_pick(input logic [3:0] sel, input logic [3:0] e,
			input logic v0, input logic v1);
		logic r;
		r = 1'b0;
		unique case (sel)
			vdls_pkg::SRC_EXP0: r = e[0];
			vdls_pkg::SRC_EXP1: r = e[1];
			vdls_pkg::SRC_EXP2: r = e[2];
			vdls_pkg::SRC_EXP3: r = e[3];
			vdls_pkg::SRC_BIAS0: r = v0;
			vdls_pkg::SRC_BIAS1: r = v1;
			vdls_pkg::SRC_X_BIAS0: r = e[0] ^ v0;
			vdls_pkg::SRC_X_BIAS1: r = e[0] ^ v1;
			vdls_pkg::SRC_X_EXP1: r = e[0] ^ e[1];
			vdls_pkg::SRC_X_EXP2: r = e[0] ^ e[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : shut_pick

	// Two-level decode: phase high gives low, low gives mid.
	function automatic logic [1:0] two_level(input logic p);
		return p ? vdls_pkg::LVL_LOW_CODE : vdls_pkg::LVL_MID_CODE;
	endfunction : two_level

	// Next-state logic: synchronisers, shutter routing, multiplexer and level mix.
	always_comb begin
		logic lc;
		logic [1:0] mid;
		lc = 1'b0;
		mid = vdls_pkg::LVL_MID_CODE;
		next_st = st;
		next_st.ph_s1 = i_vertical_phase_inputs;
		next_st.ph_s2 = st.ph_s1;
		next_st.sg_s1 = i_sensor_gate_pulses;
		next_st.sg_s2 = st.sg_s1;
		next_st.misc_s1 = {i_substrate_pulse_in, i_frame_trigger, i_bias_pulse_1,
			i_bias_pulse_0, i_exposure_pulses};
		next_st.misc_s2 = st.misc_s1;
		next_st.en_s1 = i_driver_enable_pin;
		next_st.en_s2 = st.en_s1;
		next_st.mech_shutter_out = shut_pick(i_mech_shutter_sel, ex, b0, b1);
		next_st.strobe = shut_pick(i_strobe_sel, ex, b0, b1);
		next_st.bsel = shut_pick(i_bias_select_sel, ex, b0, b1);
		unique case (i_substrate_level_source_sel)
			5'h00: lc = ph[5];
			5'h01: lc = ph[7];
			5'h02: lc = ph[8];
			5'h03: lc = ph[9];
			5'h04: lc = sg[4];
			5'h05: lc = sg[5];
			5'h06: lc = sg[6];
			5'h07: lc = sg[7];
			5'h08: lc = sg[1];
			5'h09: lc = sg[2];
			5'h0A: lc = sg[3];
			5'h0B: lc = sg[0];
			5'h0C: lc = ph[12];
			5'h0D: lc = st.bsel;
			5'h0E: lc = st.mech_shutter_out;
			5'h0F: lc = st.strobe;
			5'h10: lc = ph[0];
			5'h11: lc = ph[1];
			5'h12: lc = ph[2];
			5'h13: lc = ph[3];
			5'h14: lc = ph[4];
			5'h15: lc = ph[6];
			5'h16: lc = ph[10];
			5'h17: lc = ph[11];
			5'h18: lc = ex[0];
			5'h19: lc = ex[1];
			5'h1A: lc = ex[2];
			5'h1B: lc = ex[3];
			5'h1C: lc = ftrig;
			vdls_pkg::LC_INVALID: lc = 1'b0;
			vdls_pkg::LC_HIGH: lc = 1'b1;
			vdls_pkg::LC_LOW: lc = 1'b0;
		endcase
		next_st.lvl_ctl = lc;
		if (enable) begin
			// Mixing only while the driver is enabled.
			next_st.v1 = tl_level[0];
			next_st.v3 = tl_level[1];
			next_st.v5a = tl_level[2];
			next_st.v5b = tl_level[3];
			next_st.v7a = tl_level[4];
			next_st.v7b = tl_level[5];
			next_st.v11 = tl_level[6];
			next_st.v12 = tl_level[7];
			next_st.v2 = two_level(ph[1]);
			next_st.v4 = two_level(ph[3]);
			next_st.v6 = two_level(ph[5]);
			next_st.v8 = two_level(ph[7]);
			next_st.v9 = two_level(ph[8]);
			next_st.v10 = two_level(ph[9]);
			next_st.v13 = two_level(ph[12]);
			if (!sub_pulse) begin
				next_st.sub = vdls_pkg::SUB_HIGH;
			end else if (lc) begin
				next_st.sub = vdls_pkg::SUB_LOW;
			end else begin
				next_st.sub = vdls_pkg::SUB_MID;
			end
		end else begin
			// Disabled driver parks every vertical line at mid.
			next_st.v1 = mid;
			next_st.v2 = mid;
			next_st.v3 = mid;
			next_st.v4 = mid;
			next_st.v5a = mid;
			next_st.v5b = mid;
			next_st.v6 = mid;
			next_st.v7a = mid;
			next_st.v7b = mid;
			next_st.v8 = mid;
			next_st.v9 = mid;
			next_st.v10 = mid;
			next_st.v11 = mid;
			next_st.v12 = mid;
			next_st.v13 = mid;
			next_st.sub = vdls_pkg::SUB_LOW;
		end
	end

	// State register; reset matches the disabled-driver levels.
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
			st.v1 <= vdls_pkg::LVL_MID_CODE;
			st.v2 <= vdls_pkg::LVL_MID_CODE;
			st.v3 <= vdls_pkg::LVL_MID_CODE;
			st.v4 <= vdls_pkg::LVL_MID_CODE;
			st.v5a <= vdls_pkg::LVL_MID_CODE;
			st.v5b <= vdls_pkg::LVL_MID_CODE;
			st.v6 <= vdls_pkg::LVL_MID_CODE;
			st.v7a <= vdls_pkg::LVL_MID_CODE;
			st.v7b <= vdls_pkg::LVL_MID_CODE;
			st.v8 <= vdls_pkg::LVL_MID_CODE;
			st.v9 <= vdls_pkg::LVL_MID_CODE;
			st.v10 <= vdls_pkg::LVL_MID_CODE;
			st.v11 <= vdls_pkg::LVL_MID_CODE;
			st.v12 <= vdls_pkg::LVL_MID_CODE;
			st.v13 <= vdls_pkg::LVL_MID_CODE;
			st.sub <= vdls_pkg::SUB_LOW;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign o_v1 = st.v1;
	assign o_v2 = st.v2;
	assign o_v3 = st.v3;
	assign o_v4 = st.v4;
	assign o_phase5_out_a = st.v5a;
	assign o_phase5_out_b = st.v5b;
	assign o_v6 = st.v6;
	assign o_phase7_out_a = st.v7a;
	assign o_phase7_out_b = st.v7b;
	assign o_v8 = st.v8;
	assign o_v9 = st.v9;
	assign o_v10 = st.v10;
	assign o_v11 = st.v11;
	assign o_v12 = st.v12;
	assign o_v13 = st.v13;
	assign o_substrate_clock_out = st.sub;
	assign o_substrate_level_ctl = st.lvl_ctl;
	assign o_mech_shutter_out = st.mech_shutter_out;
	assign o_strobe_out = st.strobe;
	assign o_bias_select_out = st.bsel;
endmodule : vdls_top
`default_nettype wire

// >>> vdls_ccd_model.sv
// Behavioural sensor electrode load that flags level codes it cannot accept.
`timescale 1ns/1ps
`default_nettype none
module vdls_ccd_model (
	input wire logic [31:0] i_drive,
	output var logic o_bad_code
);
	// A code of three has no supply behind it, so it is latched as a lasting fault.
	// One process owns the flag, so it has a single driver.
	initial begin
		o_bad_code = 1'b0;
		forever begin
			@(i_drive);
			for (int i = 0; i < 16; i++) begin
				if (i_drive[2*i+:2] === 2'h3) begin
					o_bad_code = 1'b1;
				end
			end
		end
	end
endmodule : vdls_ccd_model
`default_nettype wire

// >>> vdls_top_monitor.sv
// Checker for level selection at the ports of the vertical driver block.
`timescale 1ns/1ps
`default_nettype none
module vdls_top_monitor (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [12:0] i_vertical_phase_inputs,
	input wire logic [7:0] i_sensor_gate_pulses,
	input wire logic i_substrate_pulse_in,
	input wire logic i_driver_enable_pin,
	input wire logic [4:0] i_substrate_level_source_sel,
	input wire logic [1:0] o_v1,
	input wire logic [1:0] o_phase5_out_b,
	input wire logic [1:0] o_phase7_out_b,
	input wire logic [1:0] o_v13,
	input wire logic [1:0] o_substrate_clock_out,
	input wire logic o_substrate_level_ctl
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// Inputs held for five edges have passed both synchronisers and the output register.
	sequence s_held(x);
		x [*5];
	endsequence
	a_disabled_park: assert property (s_held(!i_driver_enable_pin)
		|-> o_v1 == 2'h1 && o_v13 == 2'h1 && o_substrate_clock_out == 2'h0) else $error("Park bad.");
	a_phase_forces_low: assert property (s_held(i_driver_enable_pin && i_vertical_phase_inputs[0])
		|-> o_v1 == 2'h0) else $error("V1 not low.");
	a_v1_gate_mix: assert property (s_held(i_driver_enable_pin && !i_vertical_phase_inputs[0]
		&& $stable(i_sensor_gate_pulses[0])) |-> o_v1 == (i_sensor_gate_pulses[0] ? 2'h1 : 2'h2))
		else $error("V1 mix bad.");
	a_v5b_gate_pair: assert property (s_held(i_driver_enable_pin && !i_vertical_phase_inputs[4]
		&& $stable(i_sensor_gate_pulses[5]))
		|-> o_phase5_out_b == (i_sensor_gate_pulses[5] ? 2'h1 : 2'h2)) else $error("5B bad.");
	a_v7b_gate_pair: assert property (s_held(i_driver_enable_pin && !i_vertical_phase_inputs[6]
		&& $stable(i_sensor_gate_pulses[7]))
		|-> o_phase7_out_b == (i_sensor_gate_pulses[7] ? 2'h1 : 2'h2)) else $error("7B bad.");
	a_two_level_v13: assert property (s_held(i_driver_enable_pin
		&& $stable(i_vertical_phase_inputs[12]))
		|-> o_v13 == (i_vertical_phase_inputs[12] ? 2'h0 : 2'h1)) else $error("V13 bad.");
	a_substrate_high: assert property (s_held(i_driver_enable_pin && !i_substrate_pulse_in)
		|-> o_substrate_clock_out == 2'h2) else $error("Substrate not high.");
	a_lvlctl_const: assert property (s_held(i_substrate_level_source_sel == 5'h1E)
		|-> o_substrate_level_ctl) else $error("Constant high code bad.");
endmodule : vdls_top_monitor
bind vdls_top vdls_top_monitor u_vdls_top_monitor (.i_sys_clk, .i_reset_n,
	.i_vertical_phase_inputs, .i_sensor_gate_pulses, .i_substrate_pulse_in, .i_driver_enable_pin,
	.i_substrate_level_source_sel, .o_v1, .o_phase5_out_b, .o_phase7_out_b, .o_v13,
	.o_substrate_clock_out, .o_substrate_level_ctl);
`default_nettype wire

// >>> vdls_top_tb.sv
// Self-checking bench for the vertical driver level select block.
`timescale 1ns/1ps
`default_nettype none
module vdls_top_tb;
	logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_substrate_pulse_in = 1'b0;
	logic i_driver_enable_pin = 1'b0, i_bias_pulse_0 = 1'b0, i_bias_pulse_1 = 1'b0;
	logic i_frame_trigger = 1'b0;
	logic [12:0] i_vertical_phase_inputs = 13'h0000;
	logic [7:0] i_sensor_gate_pulses = 8'h00;
	logic [3:0] i_exposure_pulses = 4'h0, i_mech_shutter_sel = 4'h0;
	logic [3:0] i_strobe_sel = 4'h0, i_bias_select_sel = 4'h0;
	logic [4:0] i_substrate_level_source_sel = 5'h1F;
	logic [1:0] o_v1, o_v2, o_v3, o_v4, o_phase5_out_a, o_phase5_out_b, o_v6, o_phase7_out_a;
	logic [1:0] o_phase7_out_b, o_v8, o_v9, o_v10, o_v11, o_v12, o_v13, o_substrate_clock_out;
	logic o_substrate_level_ctl, o_mech_shutter_out, o_strobe_out, o_bias_select_out, bad_code;
	logic [31:0] levels;
	int fail_count = 0, n_checks = 0, cycles = 0;
	localparam int PH_IDX [15] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7, 8, 9, 10, 11, 12};
	localparam int GT_IDX [15] = '{0, -1, 2, -1, 4, 5, -1, 6, 7, -1, -1, -1, 1, 3, -1};
	localparam logic [3:0] SHP [6] = '{4'h5, 4'h3, 4'h9, 4'hE, 4'h7, 4'hD};
	localparam logic [26:0] LW [4] = '{27'h0A5F36C, 27'h05E39A5, 27'h0339C5A, 27'h06C66F1};
	vdls_top u_vdls_top (.i_sys_clk, .i_reset_n, .i_vertical_phase_inputs, .i_sensor_gate_pulses,
		.i_substrate_pulse_in, .i_driver_enable_pin, .i_exposure_pulses, .i_bias_pulse_0,
		.i_bias_pulse_1, .i_frame_trigger, .i_substrate_level_source_sel, .i_mech_shutter_sel,
		.i_strobe_sel, .i_bias_select_sel, .o_v1, .o_v2, .o_v3, .o_v4, .o_phase5_out_a,
		.o_phase5_out_b, .o_v6, .o_phase7_out_a, .o_phase7_out_b, .o_v8, .o_v9, .o_v10, .o_v11,
		.o_v12, .o_v13, .o_substrate_clock_out, .o_substrate_level_ctl, .o_mech_shutter_out,
		.o_strobe_out, .o_bias_select_out);
	// All level codes packed with V1 in the lowest pair and the substrate on top.
	assign levels = {o_substrate_clock_out, o_v13, o_v12, o_v11, o_v10, o_v9, o_v8, o_phase7_out_b,
		o_phase7_out_a, o_v6, o_phase5_out_b, o_phase5_out_a, o_v4, o_v3, o_v2, o_v1};
	vdls_ccd_model u_vdls_ccd_model (.i_drive(levels), .o_bad_code(bad_code));
	// Clock and a cycle ceiling that cuts a hang short.
	initial forever #10 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Six edges cover the synchronisers, the output register and the level-control path.
	task automatic settle;
		repeat (6) @(posedge i_sys_clk);
		#2;
	endtask : settle
	function automatic logic [31:0] expv(input logic e, input logic s, input logic c);
		logic [31:0] r;
		r[31:30] = !e ? 2'h0 : (!s ? 2'h2 : (c ? 2'h0 : 2'h1));
		for (int i = 0; i < 15; i++) begin
			if (!e) r[2*i+:2] = 2'h1;
			else if (i_vertical_phase_inputs[PH_IDX[i]]) r[2*i+:2] = 2'h0;
			else if (GT_IDX[i] < 0 || i_sensor_gate_pulses[GT_IDX[i]]) r[2*i+:2] = 2'h1;
			else r[2*i+:2] = 2'h2;
		end
		return r;
	endfunction : expv
	function automatic logic shx(input int c);
		logic e0;
		e0 = i_exposure_pulses[0];
		case (c)
			0, 1, 2, 3: shx = i_exposure_pulses[c];
			4: shx = i_bias_pulse_0;
			5: shx = i_bias_pulse_1;
			6: shx = e0 ^ i_bias_pulse_0;
			7: shx = e0 ^ i_bias_pulse_1;
			8: shx = e0 ^ i_exposure_pulses[1];
			9: shx = e0 ^ i_exposure_pulses[2];
			default: shx = 1'b0;
		endcase
	endfunction : shx
	function automatic logic lcx(input int c);
		logic [12:0] p;
		logic [7:0] g;
		logic [31:0] s;
		p = i_vertical_phase_inputs;
		g = i_sensor_gate_pulses;
		s = {3'h2, i_frame_trigger, i_exposure_pulses, p[11], p[10], p[6], p[4:0],
			i_exposure_pulses[2:1], i_bias_pulse_1, p[12], g[0], g[3:1], g[7:4], p[9:7], p[5]};
		return s[c];
	endfunction : lcx
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	// Main sequence: reset, parked levels, pairing walks, shutter routing, level-control select.
	initial begin
		repeat (6) @(posedge i_sys_clk);
		#2;
		check("reset levels", {2'h0, {15{2'h1}}}, levels);
		i_reset_n = 1'b1;
		i_vertical_phase_inputs = 13'h1555;
		i_sensor_gate_pulses = 8'hAA;
		i_substrate_pulse_in = 1'b1;
		settle();
		check("disabled levels", expv(1'b0, 1'b1, 1'b0), levels);
		i_driver_enable_pin = 1'b1;
		for (int k = 0; k < 8; k++) begin
			i_vertical_phase_inputs = 13'h0000;
			i_sensor_gate_pulses = 8'h01 << k;
			settle();
			check("gate walk", expv(1'b1, 1'b1, 1'b0), levels);
		end
		for (int k = 0; k < 13; k++) begin
			i_vertical_phase_inputs = 13'h0001 << k;
			i_sensor_gate_pulses = 8'h55;
			i_substrate_pulse_in = k[0];
			i_substrate_level_source_sel = k[1] ? vdls_pkg::LC_HIGH : vdls_pkg::LC_LOW;
			settle();
			check("phase walk", expv(1'b1, k[0], k[1]), levels);
		end
		for (int c = 0; c < 11; c++) begin
			for (int p = 0; p < 4; p++) begin
				i_exposure_pulses = {SHP[3][p], SHP[2][p], SHP[1][p], SHP[0][p]};
				i_bias_pulse_0 = SHP[4][p];
				i_bias_pulse_1 = SHP[5][p];
				i_mech_shutter_sel = c[3:0];
				i_strobe_sel = c[3:0];
				i_bias_select_sel = c[3:0];
				settle();
				check("shutter pins", {29'h0, {3{shx(c)}}},
					{29'h0, o_mech_shutter_out, o_strobe_out, o_bias_select_out});
			end
		end
		i_mech_shutter_sel = vdls_pkg::SRC_EXP1;
		i_strobe_sel = vdls_pkg::SRC_EXP2;
		i_bias_select_sel = vdls_pkg::SRC_BIAS1;
		for (int p = 0; p < 4; p++) begin
			{i_frame_trigger, i_bias_pulse_1, i_exposure_pulses, i_sensor_gate_pulses,
				i_vertical_phase_inputs} = LW[p];
			for (int c = 0; c < 32; c++) begin
				i_substrate_level_source_sel = c[4:0];
				settle();
				check("level control", {31'h0, lcx(c)}, {31'h0, o_substrate_level_ctl});
			end
		end
		i_driver_enable_pin = 1'b0;
		settle();
		check("late disable", expv(1'b0, 1'b0, 1'b0), levels);
		check("electrode codes", 32'h0, {31'h0, bad_code});
		summarize();
	end
endmodule : vdls_top_tb
`default_nettype wire
